// File: rtl/csr_pkg.sv
// constants and carrier types of the charger setpoint register bank
package csr_pkg;

  // =====================================================================
  // register offsets
  localparam logic [7:0] CSR_BATT_OFS = 8'h04;
  localparam logic [7:0] CSR_BOOST_OFS = 8'h05;
  localparam logic [7:0] CSR_VIN_OFS = 8'h06;
  localparam logic [7:0] CSR_CHARGE_CURRENT_OFS = 8'h07;
  localparam logic [7:0] CSR_PREC_OFS = 8'h08;

  // =====================================================================
  // values after reset
  localparam logic [7:0] CSR_BATT_RST = 8'h3c;
  localparam logic [7:0] CSR_BOOST_RST = 8'h67;
  localparam logic [7:0] CSR_VIN_RST = 8'h0b;
  localparam logic [7:0] CSR_CHARGE_CURRENT_RST = 8'h4c;
  localparam logic [7:0] CSR_PREC_RST = 8'ha1;
  localparam logic [7:0] CSR_UNMAPPED_RD = 8'h00;

  // =====================================================================
  // field positions
  localparam int CSR_BATT_LSB = 1;
  localparam int CSR_BOOST_LSB = 2;
  localparam int CSR_VIN_LSB = 1;
  localparam int CSR_VIN_EN_BIT = 0;
  localparam int CSR_CHARGE_CURRENT_LSB = 2;
  localparam int CSR_PREC_V_LSB = 4;

  // =====================================================================
  // saturation limits, highest code that still moves the setpoint
  localparam logic [6:0] CSR_BATT_MAX_CODE = 7'h51;
  localparam logic [5:0] CSR_BOOST_MAX_CODE = 6'h38;
  localparam logic [6:0] CSR_VIN_MAX_CODE = 7'h5f;
  localparam logic [5:0] CSR_CHARGE_CURRENT_MAX_CODE = 6'h31;

  // =====================================================================
  // decode scale: base and step in mv, ma, degrees c
  localparam logic [12:0] CSR_BATT_BASE_MV = 13'd3900;
  localparam logic [12:0] CSR_BATT_STEP_MV = 13'd10;
  localparam logic [12:0] CSR_BOOST_BASE_MV = 13'd4425;
  localparam logic [12:0] CSR_BOOST_STEP_MV = 13'd25;
  localparam logic [13:0] CSR_VIN_BASE_MV = 14'd3900;
  localparam logic [13:0] CSR_VIN_STEP_MV = 14'd100;
  localparam logic [12:0] CSR_CHARGE_CURRENT_BASE_MA = 13'd100;
  localparam logic [12:0] CSR_CHARGE_CURRENT_STEP_MA = 13'd100;
  localparam logic [11:0] CSR_PREC_V_BASE_MV = 12'd2000;
  localparam logic [11:0] CSR_PREC_V_STEP_MV = 12'd100;
  localparam logic [11:0] CSR_PREC_V_C13_MV = 12'd3400;
  localparam logic [11:0] CSR_PREC_V_C15_MV = 12'd3500;
  localparam logic [9:0] CSR_PREC_I_BASE_MA = 10'd100;
  localparam logic [9:0] CSR_PREC_I_STEP_MA = 10'd50;
  localparam logic [6:0] CSR_THERM_BASE_C = 7'd60;
  localparam logic [6:0] CSR_THERM_STEP_C = 7'd20;
  localparam logic [5:0] CSR_EOC_MIN_0 = 6'd0;
  localparam logic [5:0] CSR_EOC_MIN_1 = 6'd30;
  localparam logic [5:0] CSR_EOC_MIN_2 = 6'd45;
  localparam logic [5:0] CSR_EOC_MIN_3 = 6'd60;

  // =====================================================================
  // decoded setpoints after reset
  localparam logic [12:0] CSR_BATT_RST_MV = 13'd4200;
  localparam logic [12:0] CSR_BOOST_RST_MV = 13'd5050;
  localparam logic [6:0] CSR_THERM_RST_C = 7'd120;
  localparam logic [13:0] CSR_VIN_RST_MV = 14'd4400;
  localparam logic [12:0] CSR_CHARGE_CURRENT_RST_MA = 13'd2000;
  localparam logic [5:0] CSR_EOC_RST_MIN = 6'd0;
  localparam logic [11:0] CSR_PREC_V_RST_MV = 12'd3000;
  localparam logic [9:0] CSR_PREC_I_RST_MA = 10'd150;

  // =====================================================================
  // register access request from the serial interface engine
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } csr_req_s;

  // decoded setpoints handed to the analog loops
  typedef struct packed {
    logic [12:0] battery_regulation_voltage_mv;
    logic [12:0] boost_output_voltage_mv;
    logic [6:0] thermal_regulation_threshold_c;
    logic [13:0] input_voltage_threshold_mv;
    logic input_voltage_loop_enable;
    logic [12:0] charge_current_ma;
    logic [5:0] back_charge_min;
    logic [11:0] precharge_voltage_mv;
    logic [9:0] precharge_current_ma;
  } csr_setpoint_s;

endpackage

// File: rtl/csr_sat_clamp.sv
// saturating clamp of a setpoint code to its highest legal value
`timescale 1ns/1ps

module csr_sat_clamp #(
  parameter int W = 7,
  parameter logic [W-1:0] MAX_CODE = '1
) (
  input wire logic [W-1:0] code_in,
  output logic [W-1:0] code_out
);

  // =====================================================================
  // codes above the limit act as the limit
  always_comb
  begin
    code_out = (code_in > MAX_CODE) ? MAX_CODE : code_in;
  end

endmodule

// File: rtl/csr_setpoint_bank.sv
// charger setpoint register bank with decoded setpoint outputs
`timescale 1ns/1ps

// Contract
// - battery voltage bits 7:1, 3.9V plus 10mV steps
// - battery codes 0x51 and up give 4.71V
// - boost voltage bits 7:2, 4.425V plus 25mV
// - boost codes 0x38 and up give 5.825V
// - thermal threshold bits 1:0, 60 to 120C
// - input voltage bits 7:1, 3.9V plus 0.1V
// - input voltage codes 0x5f up saturate 13.4V
// - bit 0 enables input voltage loop
// - charge current bits 7:2, 0.1A steps
// - charge current codes 0x31 up give 5A
// - back-charge time bits 1:0, 0/30/45/60 minutes
// - precharge voltage bits 7:4, 2V to 3.5V
// - precharge current bits 3:0, 100mA plus 50mA
module csr_setpoint_bank (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire csr_pkg::csr_req_s req_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output csr_pkg::csr_setpoint_s setpoint_out
);
  import csr_pkg::*;

  logic [7:0] batt_reg;
  logic [7:0] boost_reg;
  logic [7:0] vin_reg;
  logic [7:0] charge_current_reg;
  logic [7:0] prec_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  csr_setpoint_s setpoint_reg;
  csr_setpoint_s setpoint_next;
  logic [6:0] batt_code;
  logic [5:0] boost_code;
  logic [6:0] vin_code;
  logic [5:0] charge_current_code;

  // =====================================================================
  // register writes, one process per register; unmapped offsets match none
  // battery voltage register, bit 0 is kept for software only
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      batt_reg <= CSR_BATT_RST;
    end
    else if (req_in.wr && req_in.addr == CSR_BATT_OFS)
    begin
      batt_reg <= req_in.wdata;
    end
  end

  // boost voltage and thermal threshold register
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      boost_reg <= CSR_BOOST_RST;
    end
    else if (req_in.wr && req_in.addr == CSR_BOOST_OFS)
    begin
      boost_reg <= req_in.wdata;
    end
  end

  // input voltage threshold and loop enable register
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      vin_reg <= CSR_VIN_RST;
    end
    else if (req_in.wr && req_in.addr == CSR_VIN_OFS)
    begin
      vin_reg <= req_in.wdata;
    end
  end

  // charge current and back-charge time register
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      charge_current_reg <= CSR_CHARGE_CURRENT_RST;
    end
    else if (req_in.wr && req_in.addr == CSR_CHARGE_CURRENT_OFS)
    begin
      charge_current_reg <= req_in.wdata;
    end
  end

  // precharge voltage and current register
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      prec_reg <= CSR_PREC_RST;
    end
    else if (req_in.wr && req_in.addr == CSR_PREC_OFS)
    begin
      prec_reg <= req_in.wdata;
    end
  end

  // =====================================================================
  // read mux, unmapped offsets read as zero
  always_comb
  begin
    case (req_in.addr)
      CSR_BATT_OFS: rdata_next = batt_reg;
      CSR_BOOST_OFS: rdata_next = boost_reg;
      CSR_VIN_OFS: rdata_next = vin_reg;
      CSR_CHARGE_CURRENT_OFS: rdata_next = charge_current_reg;
      CSR_PREC_OFS: rdata_next = prec_reg;
      default: rdata_next = CSR_UNMAPPED_RD;
    endcase
  end

  // read data held until the next read; a write in the same cycle is not seen yet
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      rdata_reg <= CSR_UNMAPPED_RD;
    end
    else if (req_in.rd)
    begin
      rdata_reg <= rdata_next;
    end
  end

  // valid pulses for one cycle after each read
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= req_in.rd;
    end
  end

  // =====================================================================
  // saturation of the battery, boost, input voltage and charge current fields
  csr_sat_clamp #(.W(7), .MAX_CODE(CSR_BATT_MAX_CODE)) u_batt_clamp (
    .code_in(batt_reg[7:CSR_BATT_LSB]),
    .code_out(batt_code)
  );

  csr_sat_clamp #(.W(6), .MAX_CODE(CSR_BOOST_MAX_CODE)) u_boost_clamp (
    .code_in(boost_reg[7:CSR_BOOST_LSB]),
    .code_out(boost_code)
  );

  csr_sat_clamp #(.W(7), .MAX_CODE(CSR_VIN_MAX_CODE)) u_vin_clamp (
    .code_in(vin_reg[7:CSR_VIN_LSB]),
    .code_out(vin_code)
  );

  csr_sat_clamp #(.W(6), .MAX_CODE(CSR_CHARGE_CURRENT_MAX_CODE)) u_charge_current_clamp (
    .code_in(charge_current_reg[7:CSR_CHARGE_CURRENT_LSB]),
    .code_out(charge_current_code)
  );

  // =====================================================================
  // decode codes into physical setpoints
  always_comb
  begin
    setpoint_next.battery_regulation_voltage_mv =
      CSR_BATT_BASE_MV + 13'(batt_code) * CSR_BATT_STEP_MV;
    setpoint_next.boost_output_voltage_mv =
      CSR_BOOST_BASE_MV + 13'(boost_code) * CSR_BOOST_STEP_MV;
    setpoint_next.thermal_regulation_threshold_c =
      CSR_THERM_BASE_C + 7'(boost_reg[1:0]) * CSR_THERM_STEP_C;
    setpoint_next.input_voltage_threshold_mv =
      CSR_VIN_BASE_MV + 14'(vin_code) * CSR_VIN_STEP_MV;
    setpoint_next.input_voltage_loop_enable = vin_reg[CSR_VIN_EN_BIT];
    setpoint_next.charge_current_ma =
      CSR_CHARGE_CURRENT_BASE_MA + 13'(charge_current_code) * CSR_CHARGE_CURRENT_STEP_MA;
    case (charge_current_reg[1:0])
      2'h0: setpoint_next.back_charge_min = CSR_EOC_MIN_0;
      2'h1: setpoint_next.back_charge_min = CSR_EOC_MIN_1;
      2'h2: setpoint_next.back_charge_min = CSR_EOC_MIN_2;
      default: setpoint_next.back_charge_min = CSR_EOC_MIN_3;
    endcase
    // codes 13 and 14 share 3.4V, 15 is the top step
    case (prec_reg[7:CSR_PREC_V_LSB])
      4'hd: setpoint_next.precharge_voltage_mv = CSR_PREC_V_C13_MV;
      4'he: setpoint_next.precharge_voltage_mv = CSR_PREC_V_C13_MV;
      4'hf: setpoint_next.precharge_voltage_mv = CSR_PREC_V_C15_MV;
      default: setpoint_next.precharge_voltage_mv =
        CSR_PREC_V_BASE_MV + 12'(prec_reg[7:CSR_PREC_V_LSB]) * CSR_PREC_V_STEP_MV;
    endcase
    setpoint_next.precharge_current_ma =
      CSR_PREC_I_BASE_MA + 10'(prec_reg[3:0]) * CSR_PREC_I_STEP_MA;
  end

  // =====================================================================
  // registered setpoints toward the analog loops
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      setpoint_reg.battery_regulation_voltage_mv <= CSR_BATT_RST_MV;
      setpoint_reg.boost_output_voltage_mv <= CSR_BOOST_RST_MV;
      setpoint_reg.thermal_regulation_threshold_c <= CSR_THERM_RST_C;
      setpoint_reg.input_voltage_threshold_mv <= CSR_VIN_RST_MV;
      setpoint_reg.input_voltage_loop_enable <= CSR_VIN_RST[CSR_VIN_EN_BIT];
      setpoint_reg.charge_current_ma <= CSR_CHARGE_CURRENT_RST_MA;
      setpoint_reg.back_charge_min <= CSR_EOC_RST_MIN;
      setpoint_reg.precharge_voltage_mv <= CSR_PREC_V_RST_MV;
      setpoint_reg.precharge_current_ma <= CSR_PREC_I_RST_MA;
    end
    else
    begin
      setpoint_reg <= setpoint_next;
    end
  end

  assign rdata_out = rdata_reg;
  assign rvalid_out = rvalid_reg;
  assign setpoint_out = setpoint_reg;

endmodule

// File: test/csr_setpoint_bank_props.sv
// port-level concurrent checks of the charger setpoint register bank
`timescale 1ns/1ps

module csr_setpoint_bank_props (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire csr_pkg::csr_req_s req_in,
  input wire logic [7:0] rdata_out,
  input wire logic rvalid_out,
  input wire csr_pkg::csr_setpoint_s setpoint_out
);
  import csr_pkg::*;

  // =====================================================================
  // decode helpers: saturating linear map and the two table fields
  function automatic int lin(int c, int mx, int base, int step);
    return base + step * ((c > mx) ? mx : c);
  endfunction
  function automatic int prec_mv(int c);
    return (c < 13) ? 2000 + 100 * c : (c < 15) ? 3400 : 3500;
  endfunction
  function automatic int eoc_min(int c);
    return (c == 0) ? 0 : 15 + 15 * c;
  endfunction

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  // =====================================================================
  // decoded setpoints follow a write two edges later
  a_batt_decode: assert property (req_in.wr && req_in.addr == CSR_BATT_OFS |-> ##2
    setpoint_out.battery_regulation_voltage_mv == lin($past(req_in.wdata, 2) >> 1, 81, 3900, 10))
    else $error("battery setpoint mismatch");
  a_boost_decode: assert property (req_in.wr && req_in.addr == CSR_BOOST_OFS |-> ##2
    setpoint_out.boost_output_voltage_mv == lin($past(req_in.wdata, 2) >> 2, 56, 4425, 25)
    && setpoint_out.thermal_regulation_threshold_c == 60 + 20 * ($past(req_in.wdata, 2) % 4))
    else $error("boost or thermal setpoint mismatch");
  a_vin_decode: assert property (req_in.wr && req_in.addr == CSR_VIN_OFS |-> ##2
    setpoint_out.input_voltage_threshold_mv == lin($past(req_in.wdata, 2) >> 1, 95, 3900, 100)
    && setpoint_out.input_voltage_loop_enable == $past(req_in.wdata, 2) % 2)
    else $error("input voltage setpoint mismatch");
  a_charge_current_decode: assert property (req_in.wr && req_in.addr == CSR_CHARGE_CURRENT_OFS |-> ##2
    setpoint_out.charge_current_ma == lin($past(req_in.wdata, 2) >> 2, 49, 100, 100)
    && setpoint_out.back_charge_min == eoc_min($past(req_in.wdata, 2) % 4))
    else $error("charge current setpoint mismatch");
  a_prec_decode: assert property (req_in.wr && req_in.addr == CSR_PREC_OFS |-> ##2
    setpoint_out.precharge_voltage_mv == prec_mv($past(req_in.wdata, 2) / 16)
    && setpoint_out.precharge_current_ma == 100 + 50 * ($past(req_in.wdata, 2) % 16))
    else $error("precharge setpoint mismatch");

  // =====================================================================
  // reset values and read handshake
  a_reset_decode: assert property ($rose(rstn_in) |->
    setpoint_out == {13'd4200, 13'd5050, 7'd120, 14'd4400, 1'b1, 13'd2000, 6'd0, 12'd3000, 10'd150})
    else $error("reset setpoint mismatch");
  a_read_pulse: assert property (req_in.rd |=> rvalid_out) else $error("read not answered");
  a_read_quiet: assert property (!req_in.rd |=> !rvalid_out && $stable(rdata_out))
    else $error("read answer without request");
  a_unmapped_zero: assert property (req_in.rd && (req_in.addr < 8'h04 || req_in.addr > 8'h08)
    |=> rdata_out == CSR_UNMAPPED_RD) else $error("unmapped read not zero");
endmodule

// File: test/charger_setpoint_registers_bench.sv
// self-checking bench of the charger setpoint register bank
`timescale 1ns/1ps

module charger_setpoint_registers_bench;
  import csr_pkg::*;
  logic core_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  csr_req_s req = '0;
  logic [7:0] rdata;
  logic rvalid;
  csr_setpoint_s sp;
  int failures = 0;
  int n_tests = 0;

  // 25 MHz clock
  always #20 core_clk_in = ~core_clk_in;

  csr_setpoint_bank dut_u (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .req_in(req), .rdata_out(rdata),
    .rvalid_out(rvalid), .setpoint_out(sp));

  // =====================================================================
  // shared tasks; all are entered and left 1 ns after a rising edge
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req.addr = a;
    req.rd = 1'b1;
    @(posedge core_clk_in);
    #1 req.rd = 1'b0;
    chk(rvalid, 1'b1);
    chk(rdata, exp);
    // one idle edge: valid drops, data stays until the next read
    @(posedge core_clk_in);
    #1 chk({rvalid, rdata}, {1'b0, exp});
  endtask
  // single write; wr is low again on return
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(posedge core_clk_in);
    #1 req.wr = 1'b0;
  endtask
  // write, then read back; setpoints have settled on return
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    rd(a, d);
  endtask
  task automatic summarize;
    if (failures == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // =====================================================================
  // scenarios
  task automatic t_reset;
    csr_setpoint_s sp_rst;
    sp_rst = {13'd4200, 13'd5050, 7'd120, 14'd4400, 1'b1, 13'd2000, 6'd0, 12'd3000, 10'd150};
    rstn_in = 1'b0;
    repeat (10) @(posedge core_clk_in);
    #1 rstn_in = 1'b1;
    chk(sp, sp_rst);
    chk({rvalid, rdata}, {1'b0, CSR_UNMAPPED_RD});
    rd(CSR_BATT_OFS, 8'h3c);
    rd(CSR_BOOST_OFS, 8'h67);
    rd(CSR_VIN_OFS, 8'h0b);
    rd(CSR_CHARGE_CURRENT_OFS, 8'h4c);
    rd(CSR_PREC_OFS, 8'ha1);
  endtask
  task automatic t_sat;
    put(8'h04, 8'ha3);
    chk(sp.battery_regulation_voltage_mv, 96'd4710);
    put(8'h04, 8'hff);
    chk(sp.battery_regulation_voltage_mv, 96'd4710);
    put(8'h04, 8'ha0);
    chk(sp.battery_regulation_voltage_mv, 96'd4700);
    put(8'h04, 8'h00);
    chk(sp.battery_regulation_voltage_mv, 96'd3900);
    put(8'h05, 8'he4);
    chk(sp.boost_output_voltage_mv, 96'd5825);
    put(8'h05, 8'hff);
    chk(sp.boost_output_voltage_mv, 96'd5825);
    put(8'h06, 8'hbe);
    chk({sp.input_voltage_threshold_mv, sp.input_voltage_loop_enable}, {14'd13400, 1'b0});
    put(8'h06, 8'hc3);
    chk({sp.input_voltage_threshold_mv, sp.input_voltage_loop_enable}, {14'd13400, 1'b1});
    put(8'h06, 8'h02);
    chk(sp.input_voltage_threshold_mv, 96'd4000);
    // software raises the overcurrent level before a high charge current; that register lies outside this bank
    wr(8'h0d, 8'h04);
    rd(8'h0d, CSR_UNMAPPED_RD);
    put(8'h07, 8'hc4);
    chk(sp.charge_current_ma, 96'd5000);
    put(8'h07, 8'hc8);
    chk(sp.charge_current_ma, 96'd5000);
  endtask
  task automatic t_codes;
    for (int i = 0; i < 16; i++)
    begin
      put(CSR_PREC_OFS, {4'(i), 4'(15 - i)});
      chk(sp.precharge_voltage_mv, 96'((i < 13) ? 2000 + 100 * i : (i < 15) ? 3400 : 3500));
      chk(sp.precharge_current_ma, 96'(100 + 50 * (15 - i)));
    end
    for (int i = 0; i < 4; i++)
    begin
      put(CSR_BOOST_OFS, {6'h19, 2'(i)});
      chk(sp.thermal_regulation_threshold_c, 96'(60 + 20 * i));
      put(CSR_CHARGE_CURRENT_OFS, {6'h00, 2'(i)});
      chk(sp.back_charge_min, 96'((i == 0) ? 0 : 15 + 15 * i));
    end
  endtask
  // unmapped writes are dropped, then a write and read in one cycle
  task automatic t_edges;
    put(8'h09, 8'h00);
    wr(8'h03, 8'h5a);
    rd(8'h03, CSR_UNMAPPED_RD);
    rd(8'hff, CSR_UNMAPPED_RD);
    rd(CSR_PREC_OFS, 8'hf0);
    req.addr = CSR_BATT_OFS;
    req.wdata = 8'h55;
    req.wr = 1'b1;
    req.rd = 1'b1;
    @(posedge core_clk_in);
    #1 req.wr = 1'b0;
    chk({rvalid, rdata}, {1'b1, 8'h00});
    rd(CSR_BATT_OFS, 8'h55);
    chk(sp.battery_regulation_voltage_mv, 96'd4320);
  endtask

  initial
  begin
    t_reset();
    t_sat();
    t_codes();
    t_edges();
    t_reset();
    summarize();
  end
endmodule

bind csr_setpoint_bank csr_setpoint_bank_props chk_u (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .req_in(req_in),
  .rdata_out(rdata_out), .rvalid_out(rvalid_out), .setpoint_out(setpoint_out));
